// ===== inc/nand_host_pkg.sv
// Purpose: shared constants for the flash host controller
// Assumes: 8-bit asynchronous flash, strobes made from a 200 MHz clock
// Notes: register offsets are byte addresses on the apb side
package nand_host_pkg;
   localparam logic [7:0] cmd_read = 8'h00;
   localparam logic [7:0] cmd_read_start = 8'h30;
   localparam logic [7:0] cmd_prog_setup = 8'h80;
   localparam logic [7:0] cmd_col_change = 8'h85;
   localparam logic [7:0] cmd_prog_go = 8'h10;
   localparam logic [7:0] cmd_prog_multi = 8'h11;
   localparam logic [7:0] cmd_prog_cache = 8'h15;
   localparam logic [7:0] cmd_cache_31 = 8'h31;
   localparam logic [7:0] cmd_erase_setup = 8'h60;
   localparam logic [7:0] cmd_erase_go = 8'hd0;
   localparam logic [7:0] cmd_status = 8'h70;
   localparam logic [7:0] cmd_status_mp = 8'h71;
   localparam logic [7:0] cmd_reset = 8'hff;
   localparam logic [7:0] cmd_read_id = 8'h90;
   localparam logic [11:0] off_ctrl = 12'h000;
   localparam logic [11:0] off_data = 12'h004;
   localparam logic [11:0] off_stat = 12'h008;
   localparam logic [11:0] off_pstat = 12'h00c;
   localparam logic [11:0] off_bad = 12'h010;
   localparam logic [11:0] off_badcnt = 12'h014;
   localparam int ctrl_kind_lsb = 8;
   localparam int ctrl_wp_bit = 16;
   localparam logic [1:0] kind_cmd = 2'h0;
   localparam logic [1:0] kind_addr = 2'h1;
   localparam logic [1:0] kind_wr = 2'h2;
   localparam logic [1:0] kind_rd = 2'h3;
   localparam int st_fail1 = 0;
   localparam int st_fail2 = 1;
   localparam int st_pb_rdy = 5;
   localparam int st_dc_rdy = 6;
   localparam int st_unprot = 7;
   localparam int max_partial = 4;
   localparam int blocks_total = 4096;
   localparam int blocks_min_good = 4016;
   localparam int blk_w = 12;
   localparam int page_w = 6;
   localparam int clk_mhz = 200;
   localparam int strobe_ns = 25;
   localparam int strobe_cyc = (strobe_ns * clk_mhz + 999) / 1000;
endpackage : nand_host_pkg

// ===== hdl/nand_host.sv
// Purpose: apb-driven host controller that strobes an asynchronous flash
// Assumes: software writes one cycle at a time; flash pins are asynchronous to I_CLK
// Notes: this side keeps the host duties; checks refuse illegal commands
// What this block does
// - during power-up busy only reset or status read are sent.
// - never send an undefined command code.
// - while busy send only 70h, 71h or reset.
// - after 80h send only 85h, 10h, 11h, 15h or reset.
// - pages of a block are programmed in ascending order.
// - at most four partial programs per page between erases; code counts repeats of the last programmed page, an erase does not clear it.
// - never erase a block known bad; track bad blocks.
// - after 70h the status byte is read with the read strobe.
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module nand_host (
   input wire logic I_CLK,
   input wire logic I_SRST,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   output logic o_chip_en_n,
   output logic o_cmd_latch,
   output logic o_addr_latch,
   output logic o_write_strobe_n,
   output logic o_read_strobe_n,
   output logic o_write_prot_n,
   input wire logic [7:0] i_io,
   output logic [7:0] o_io,
   output logic o_io_oe,
   input wire logic i_ready_busy_n
);
   typedef enum logic [1:0] {s_idle = 2'b00, s_setup = 2'b01, s_low = 2'b11,
      s_high = 2'b10} bus_state_t;
   bus_state_t state_reg;
   logic [2:0] rb_sync_reg;
   logic rb_reg;
   logic [7:0] cnt_reg;
   logic [1:0] kind_reg;
   logic [7:0] byte_reg;
   logic [7:0] rdata_reg;
   logic [7:0] last_cmd_reg;
   logic prog_open_reg;
   logic in_read_reg;
   logic held_status_reg;
   logic [7:0] status_reg;
   logic wp_n_reg;
   logic err_reg;
   localparam int blk_w_l = nand_host_pkg::blk_w;
   localparam int page_w_l = nand_host_pkg::page_w;
   logic [2:0] addr_n_reg;
   logic [blk_w_l-1:0] cur_blk_reg;
   logic [page_w_l-1:0] cur_page_reg;
   logic [page_w_l:0] next_page_reg [0:nand_host_pkg::blocks_total-1];
   logic bad_reg [0:nand_host_pkg::blocks_total-1];
   logic [12:0] bad_cnt_reg;
   logic [2:0] partial_reg;
   logic [blk_w_l+page_w_l-1:0] part_key_reg;
   logic wr_en;
   logic rd_en;
   logic start_ok;
   logic is_known;
   logic allowed;
   logic [7:0] cnt_max;

   // defined command set, used for every outgoing command byte
   function automatic logic known_cmd(input logic [7:0] c);
      case (c)
         nand_host_pkg::cmd_read, nand_host_pkg::cmd_read_start,
         nand_host_pkg::cmd_prog_setup, nand_host_pkg::cmd_col_change,
         nand_host_pkg::cmd_prog_go, nand_host_pkg::cmd_prog_multi,
         nand_host_pkg::cmd_prog_cache, nand_host_pkg::cmd_cache_31,
         nand_host_pkg::cmd_erase_setup, nand_host_pkg::cmd_erase_go,
         nand_host_pkg::cmd_status, nand_host_pkg::cmd_status_mp,
         nand_host_pkg::cmd_reset, nand_host_pkg::cmd_read_id: known_cmd = 1'b1;
         default: known_cmd = 1'b0;
      endcase
   endfunction : known_cmd

   function automatic logic is_prog_end(input logic [7:0] c);
      is_prog_end = (c == nand_host_pkg::cmd_prog_go) || (c == nand_host_pkg::cmd_prog_multi)
         || (c == nand_host_pkg::cmd_prog_cache);
   endfunction : is_prog_end

   assign wr_en = i_psel && i_penable && i_pwrite;
   assign rd_en = i_psel && i_penable && !i_pwrite;
   assign cnt_max = 8'(nand_host_pkg::strobe_cyc - 1);
   assign is_known = known_cmd(i_pwdata[7:0]);

   // gate on the host duties before a command byte leaves
   always_comb begin
      allowed = is_known;
      if (i_pwdata[7:0] == nand_host_pkg::cmd_reset) begin
         allowed = 1'b1;
      end else if (!rb_reg) begin
         allowed = (i_pwdata[7:0] == nand_host_pkg::cmd_status)
            || (i_pwdata[7:0] == nand_host_pkg::cmd_status_mp);
      end else if (prog_open_reg) begin
         allowed = (i_pwdata[7:0] == nand_host_pkg::cmd_col_change)
            || is_prog_end(i_pwdata[7:0]);
      end else if (i_pwdata[7:0] == nand_host_pkg::cmd_erase_go) begin
         allowed = !bad_reg[cur_blk_reg];
      end else if (is_prog_end(i_pwdata[7:0])) begin
         allowed = 1'b1;
      end
   end

   // data-port write to the command/address/data register launches a cycle
   always_comb begin
      start_ok = 1'b0;
      if (wr_en && (i_paddr == nand_host_pkg::off_data)) begin
         unique case (i_pwdata[nand_host_pkg::ctrl_kind_lsb +: 2])
            nand_host_pkg::kind_cmd: start_ok = allowed;
            nand_host_pkg::kind_addr: start_ok = (addr_n_reg < 3'h5);
            nand_host_pkg::kind_wr: start_ok = !prog_open_reg
               || ((next_page_reg[cur_blk_reg][page_w_l-1:0] <= cur_page_reg)
               && (partial_reg < 3'(nand_host_pkg::max_partial)));
            nand_host_pkg::kind_rd: start_ok = 1'b1;
         endcase
      end
   end

   assign o_pready = (state_reg == s_idle) || !(i_paddr == nand_host_pkg::off_data);
   assign o_pslverr = wr_en && o_pready && (i_paddr == nand_host_pkg::off_data)
      && !start_ok;

   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         rb_sync_reg <= 3'h0;
         rb_reg <= 1'b0;
      end else begin
         rb_sync_reg <= {rb_sync_reg[1:0], i_ready_busy_n};
         if (rb_sync_reg[2] == rb_sync_reg[1]) begin
            rb_reg <= rb_sync_reg[2];
         end
      end
   end

   // strobe sequencer: setup, strobe low, strobe high
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         state_reg <= s_idle;
         cnt_reg <= 8'h00;
         kind_reg <= 2'h0;
         byte_reg <= 8'h00;
         rdata_reg <= 8'h00;
      end else begin
         unique case (state_reg)
            s_idle: if (start_ok) begin
               kind_reg <= i_pwdata[nand_host_pkg::ctrl_kind_lsb +: 2];
               byte_reg <= i_pwdata[7:0];
               cnt_reg <= 8'h00;
               state_reg <= s_setup;
            end
            s_setup: state_reg <= s_low;
            s_low: if (cnt_reg == cnt_max) begin
               cnt_reg <= 8'h00;
               if (kind_reg == nand_host_pkg::kind_rd) begin
                  rdata_reg <= i_io;
               end
               state_reg <= s_high;
            end else begin
               cnt_reg <= cnt_reg + 8'h01;
            end
            s_high: if (cnt_reg == cnt_max) begin
               state_reg <= s_idle;
            end else begin
               cnt_reg <= cnt_reg + 8'h01;
            end
         endcase
      end
   end

   // command bookkeeping for program, read and status tracking
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         last_cmd_reg <= nand_host_pkg::cmd_reset;
         prog_open_reg <= 1'b0;
         in_read_reg <= 1'b0;
         held_status_reg <= 1'b0;
         addr_n_reg <= 3'h0;
         cur_blk_reg <= '0;
         cur_page_reg <= '0;
         partial_reg <= 3'h0;
         part_key_reg <= '0;
      end else if (state_reg == s_idle && start_ok) begin
         if (i_pwdata[nand_host_pkg::ctrl_kind_lsb +: 2] == nand_host_pkg::kind_cmd) begin
            last_cmd_reg <= i_pwdata[7:0];
            addr_n_reg <= 3'h0;
            if (i_pwdata[7:0] == nand_host_pkg::cmd_prog_setup) begin
               prog_open_reg <= 1'b1;
            end else if (i_pwdata[7:0] != nand_host_pkg::cmd_col_change) begin
               prog_open_reg <= 1'b0;
            end
            if (i_pwdata[7:0] == nand_host_pkg::cmd_read_start) begin
               in_read_reg <= 1'b1;
            end else if (i_pwdata[7:0] == nand_host_pkg::cmd_status) begin
               held_status_reg <= in_read_reg;
            end else if (i_pwdata[7:0] == nand_host_pkg::cmd_read) begin
               held_status_reg <= 1'b0;
            end else begin
               in_read_reg <= 1'b0;
               held_status_reg <= 1'b0;
            end
            if (is_prog_end(i_pwdata[7:0]) && prog_open_reg) begin
               if (part_key_reg == {cur_blk_reg, cur_page_reg}) begin
                  partial_reg <= partial_reg + 3'h1;
               end else begin
                  partial_reg <= 3'h1;
                  part_key_reg <= {cur_blk_reg, cur_page_reg};
               end
            end
         end else if (i_pwdata[nand_host_pkg::ctrl_kind_lsb +: 2] == nand_host_pkg::kind_addr) begin
            addr_n_reg <= addr_n_reg + 3'h1;
            if (addr_n_reg == 3'h2) begin
               cur_page_reg <= i_pwdata[page_w_l-1:0];
               cur_blk_reg[1:0] <= i_pwdata[7:6];
            end else if (addr_n_reg == 3'h3) begin
               cur_blk_reg[9:2] <= i_pwdata[7:0];
            end else if (addr_n_reg == 3'h4) begin
               cur_blk_reg[11:10] <= i_pwdata[1:0];
            end
         end
      end
   end

   // per-block next-page pointer and bad-block table
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         bad_cnt_reg <= 13'h0000;
         for (int b = 0; b < nand_host_pkg::blocks_total; b++) begin
            next_page_reg[b] <= '0;
            bad_reg[b] <= 1'b0;
         end
      end else begin
         if (state_reg == s_idle && start_ok && i_pwdata[9:8] == nand_host_pkg::kind_cmd) begin
            if (i_pwdata[7:0] == nand_host_pkg::cmd_erase_go) begin
               next_page_reg[cur_blk_reg] <= '0;
            end else if (is_prog_end(i_pwdata[7:0]) && prog_open_reg) begin
               next_page_reg[cur_blk_reg] <= {1'b0, cur_page_reg};
            end
         end
         if (wr_en && i_paddr == nand_host_pkg::off_bad
            && !bad_reg[i_pwdata[blk_w_l-1:0]]) begin
            bad_reg[i_pwdata[blk_w_l-1:0]] <= 1'b1;
            bad_cnt_reg <= bad_cnt_reg + 13'h0001;
         end
      end
   end

   // status byte capture after a status read
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         status_reg <= 8'h00;
         wp_n_reg <= 1'b0;
         err_reg <= 1'b0;
      end else begin
         if (state_reg == s_low && cnt_reg == cnt_max && kind_reg == nand_host_pkg::kind_rd
            && (last_cmd_reg == nand_host_pkg::cmd_status
            || last_cmd_reg == nand_host_pkg::cmd_status_mp)) begin
            status_reg <= i_io;
         end
         if (wr_en && i_paddr == nand_host_pkg::off_ctrl) begin
            wp_n_reg <= i_pwdata[nand_host_pkg::ctrl_wp_bit];
         end
         if (o_pslverr) begin
            err_reg <= 1'b1;
         end else if (wr_en && i_paddr == nand_host_pkg::off_stat) begin
            err_reg <= 1'b0;
         end
      end
   end

   always_comb begin
      o_prdata = 32'h00000000;
      if (rd_en) begin
         unique case (i_paddr)
            nand_host_pkg::off_ctrl: o_prdata = {15'h0000, wp_n_reg, 16'h0000};
            nand_host_pkg::off_data: o_prdata = {24'h000000, rdata_reg};
            nand_host_pkg::off_stat: o_prdata = {25'h0, held_status_reg, prog_open_reg,
               in_read_reg, err_reg, 1'b0, (state_reg != s_idle), rb_reg};
            nand_host_pkg::off_pstat: o_prdata = {24'h000000, status_reg};
            nand_host_pkg::off_badcnt: o_prdata = {19'h00000, bad_cnt_reg};
            default: o_prdata = 32'h00000000;
         endcase
      end
   end

   assign o_chip_en_n = 1'b0;
   assign o_write_prot_n = wp_n_reg;
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         o_cmd_latch <= 1'b0;
         o_addr_latch <= 1'b0;
         o_write_strobe_n <= 1'b1;
         o_read_strobe_n <= 1'b1;
         o_io <= 8'h00;
         o_io_oe <= 1'b0;
      end else begin
         o_cmd_latch <= (state_reg == s_idle) ? (start_ok
            && i_pwdata[9:8] == nand_host_pkg::kind_cmd)
            : (kind_reg == nand_host_pkg::kind_cmd && !(state_reg == s_high
            && cnt_reg == cnt_max));
         o_addr_latch <= (state_reg == s_idle) ? (start_ok
            && i_pwdata[9:8] == nand_host_pkg::kind_addr)
            : (kind_reg == nand_host_pkg::kind_addr && !(state_reg == s_high
            && cnt_reg == cnt_max));
         o_write_strobe_n <= !((state_reg == s_setup || (state_reg == s_low
            && cnt_reg != cnt_max)) && kind_reg != nand_host_pkg::kind_rd);
         o_read_strobe_n <= !((state_reg == s_setup || (state_reg == s_low
            && cnt_reg != cnt_max)) && kind_reg == nand_host_pkg::kind_rd);
         o_io <= (state_reg == s_idle) ? i_pwdata[7:0] : byte_reg;
         o_io_oe <= (state_reg == s_idle) ? (start_ok
            && i_pwdata[9:8] != nand_host_pkg::kind_rd)
            : (kind_reg != nand_host_pkg::kind_rd && !(state_reg == s_high
            && cnt_reg == cnt_max));
      end
   end
endmodule : nand_host

// ===== verification/nand_host_monitor.sv
// Purpose: pin and apb protocol checks for nand_host
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every nand_host instance
`timescale 1ns/10ps
module nand_host_monitor (
   input wire logic I_CLK,
   input wire logic I_SRST,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic o_pready,
   input wire logic [31:0] o_prdata,
   input wire logic o_pslverr,
   input wire logic o_chip_en_n,
   input wire logic o_cmd_latch,
   input wire logic o_addr_latch,
   input wire logic o_write_strobe_n,
   input wire logic o_read_strobe_n,
   input wire logic o_write_prot_n,
   input wire logic [7:0] i_io,
   input wire logic [7:0] o_io,
   input wire logic o_io_oe,
   input wire logic i_ready_busy_n
);
   logic we_d_reg;
   logic [7:0] last_cmd_reg;
   logic cmd_edge;
   logic defined;
   assign cmd_edge = o_cmd_latch && !o_write_strobe_n && we_d_reg;
   assign defined = o_io inside {8'h00, 8'h30, 8'h80, 8'h85, 8'h10, 8'h11, 8'h15, 8'h31,
      8'h60, 8'hd0, 8'h70, 8'h71, 8'hff, 8'h90};
   always_ff @(posedge I_CLK) begin
      we_d_reg <= o_write_strobe_n;
   end
   // last command put on the pins
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         last_cmd_reg <= 8'h00;
      end else if (cmd_edge) begin
         last_cmd_reg <= o_io;
      end
   end
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (I_SRST);
   sequence s_rd_low; (!o_read_strobe_n && !o_io_oe) [*5] ##1 o_read_strobe_n; endsequence
   sequence s_wr_hold;
      (!o_write_strobe_n && o_io_oe && $stable(o_io)) [*4] ##1 o_write_strobe_n;
   endsequence
   property p_rd_width; $fell(o_read_strobe_n) |-> s_rd_low; endproperty
   a_rd_width: assert property (p_rd_width) else $error("read strobe window wrong");
   property p_wr_hold; $fell(o_write_strobe_n) |-> o_io_oe ##1 s_wr_hold; endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write strobe window wrong");
   property p_excl; !(!o_write_strobe_n && !o_read_strobe_n); endproperty
   a_excl: assert property (p_excl) else $error("both strobes low");
   property p_defined; cmd_edge |-> defined; endproperty
   a_defined: assert property (p_defined) else $error("undefined command sent");
   property p_busy_cmd;
      (!i_ready_busy_n) [*8] ##1 cmd_edge |-> o_io inside {8'h70, 8'h71, 8'hff};
   endproperty
   a_busy_cmd: assert property (p_busy_cmd) else $error("command sent while busy");
   property p_after_setup;
      cmd_edge && last_cmd_reg == 8'h80 |-> o_io inside {8'h85, 8'h10, 8'h11, 8'h15, 8'hff};
   endproperty
   a_after_setup: assert property (p_after_setup) else $error("bad command after 80h");
   property p_refuse;
      o_pslverr |-> i_psel && i_penable && i_pwrite && i_paddr == nand_host_pkg::off_data;
   endproperty
   a_refuse: assert property (p_refuse) else $error("error outside data write");
   property p_wp;
      $changed(o_write_prot_n)
         |-> $past(i_psel && i_penable && i_pwrite && i_paddr == nand_host_pkg::off_ctrl);
   endproperty
   a_wp: assert property (p_wp) else $error("write protect moved by itself");
endmodule : nand_host_monitor
bind nand_host nand_host_monitor i_mon (.I_CLK, .I_SRST, .i_psel, .i_penable, .i_pwrite,
   .i_paddr, .i_pwdata, .o_pready, .o_prdata, .o_pslverr, .o_chip_en_n, .o_cmd_latch,
   .o_addr_latch, .o_write_strobe_n, .o_read_strobe_n, .o_write_prot_n, .i_io, .o_io,
   .o_io_oe, .i_ready_busy_n);

// ===== verification/flash_model.sv
// Purpose: behavioural flash device answering the host strobes
// Assumes: busy pulls the shared open-drain line low
// Notes: times in ns; program pass or fail comes from fail_pgm
`timescale 1ns/10ps
module flash_model #(
   parameter int PWR_NS = 300,
   parameter int BUSY_NS = 400,
   parameter int RST_NS = 100
) (
   input wire logic cle,
   input wire logic ale,
   input wire logic we_n,
   input wire logic read_strobe_n,
   input wire logic wp_n,
   input wire logic fail_pgm,
   input wire logic [7:0] din,
   output logic [7:0] dout,
   output logic pull_low
);
   logic busy = 1'b1;
   logic stat_mode = 1'b0;
   logic loading = 1'b0;
   logic fail1 = 1'b0;
   logic fail2 = 1'b0;
   logic [7:0] col = 8'h00;
   realtime t_end = PWR_NS;
   initial dout = 8'h00;
   assign pull_low = busy;
   always #1 if (busy && $realtime >= t_end) busy = 1'b0;
   always @(negedge wp_n) if ($realtime > PWR_NS) t_end = $realtime;
   always @(posedge we_n) begin
      // address bytes are not decoded, so a sixth is harmless
      if (ale) col = 8'h00;
      if (cle) begin
         stat_mode = (din == 8'h70 || din == 8'h71);
         if (din == 8'hff) begin
            t_end = $realtime + RST_NS;
            busy = 1'b1;
         end
         if ((((din == 8'h10 || din == 8'h15) && loading) || din == 8'hd0) && wp_n) begin
            fail2 = fail1;
            fail1 = fail_pgm;
            t_end = $realtime + BUSY_NS;
            busy = 1'b1;
         end
         // only 85h keeps a data load open; anything else drops it
         loading = (din == 8'h80) || (loading && din == 8'h85);
      end
   end
   always @(negedge read_strobe_n) begin
      if (stat_mode) dout = {wp_n, !busy, !busy, 3'h0, fail2, fail1};
      else begin
         dout = col;
         col = col + 8'h01;
      end
   end
   always @(posedge read_strobe_n) #3 dout = ~dout;
endmodule : flash_model

// ===== verification/flash_status_reset_cmd_rules_bench.sv
// Purpose: self-checking bench for the flash host controller
// Assumes: apb master in the bench, behavioural flash beside the design
// Notes: plain accesses sit in a table, programming order and reset by hand
`timescale 1ns/10ps
module flash_status_reset_cmd_rules_bench;
   typedef struct packed {
      logic [1:0] op;
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] e;
   } row_t;
   localparam logic [11:0] dt = nand_host_pkg::off_data;
   localparam logic [11:0] st = nand_host_pkg::off_stat;
   localparam logic [11:0] ps = nand_host_pkg::off_pstat;
   // op 0 write expecting the error flag, 1 read expecting data, 2 wait for ready
   localparam row_t rows [37] = '{'{2'h2, st, 32'h0, 32'h0}, '{2'h0, dt, 32'h70, 32'h0},
      '{2'h0, dt, 32'h300, 32'h0}, '{2'h1, ps, 32'h0, 32'h60}, '{2'h0, 12'h0, 32'h10000, 32'h0},
      '{2'h0, st, 32'h0, 32'h0}, '{2'h0, dt, 32'h30, 32'h0}, '{2'h0, dt, 32'h70, 32'h0},
      '{2'h1, st, 32'h0, 32'h51}, '{2'h0, dt, 32'h0, 32'h0}, '{2'h1, st, 32'h0, 32'h11},
      '{2'h0, dt, 32'h70, 32'h0}, '{2'h0, dt, 32'h300, 32'h0}, '{2'h1, ps, 32'h0, 32'he0},
      '{2'h0, dt, 32'hee, 32'h1}, '{2'h1, st, 32'h0, 32'h59}, '{2'h0, dt, 32'h80, 32'h0},
      '{2'h0, dt, 32'h60, 32'h1},
      '{2'h0, dt, 32'h85, 32'h0}, '{2'h0, dt, 32'h10, 32'h0}, '{2'h1, 12'h20, 32'h0, 32'h0},
      '{2'h0, dt, 32'h60, 32'h1}, '{2'h0, dt, 32'h71, 32'h0}, '{2'h0, dt, 32'hff, 32'h0},
      '{2'h2, st, 32'h0, 32'h0}, '{2'h0, 12'h10, 32'h5, 32'h0}, '{2'h0, dt, 32'h60, 32'h0},
      '{2'h0, dt, 32'h100, 32'h0}, '{2'h0, dt, 32'h100, 32'h0}, '{2'h0, dt, 32'h140, 32'h0},
      '{2'h0, dt, 32'h101, 32'h0}, '{2'h0, dt, 32'h100, 32'h0}, '{2'h0, dt, 32'h100, 32'h1},
      '{2'h0, dt, 32'hd0, 32'h1}, '{2'h0, dt, 32'hff, 32'h0}, '{2'h2, st, 32'h0, 32'h0},
      '{2'h1, 12'h14, 32'h0, 32'h1}};
   logic I_CLK, I_SRST, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_cmd_latch;
   logic o_addr_latch, o_write_strobe_n, o_read_strobe_n, o_write_prot_n, o_io_oe;
   logic i_ready_busy_n, pull_low, fail_pgm, e, o_chip_en_n;
   logic [11:0] i_paddr;
   logic [31:0] i_pwdata, o_prdata, q;
   logic [7:0] i_io, o_io;
   int n_fail = 0;
   int compares = 0;
   nand_host i_dut (.I_CLK, .I_SRST, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
      .o_pready, .o_prdata, .o_pslverr, .o_chip_en_n, .o_cmd_latch, .o_addr_latch,
      .o_write_strobe_n, .o_read_strobe_n, .o_write_prot_n, .i_io, .o_io, .o_io_oe,
      .i_ready_busy_n);
   flash_model i_flash (.cle (o_cmd_latch), .ale (o_addr_latch), .we_n (o_write_strobe_n),
      .read_strobe_n (o_read_strobe_n), .wp_n (o_write_prot_n), .fail_pgm, .din (o_io),
      .dout (i_io), .pull_low);
   assign i_ready_busy_n = pull_low ? 1'b0 : 1'b1;
   initial begin
      I_CLK = 1'b0;
      forever #2.5 I_CLK = ~I_CLK;
   end
   task automatic complete_run;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge I_CLK);
      i_penable <= 1'b1;
      n = 0;
      do begin
         @(posedge I_CLK);
         n++;
      end while (o_pready !== 1'b1 && n < 100);
      q = o_prdata;
      e = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      @(posedge I_CLK);
      if (n >= 100) begin
         n_fail++;
         complete_run();
      end
   endtask : apb
   task automatic wait_rdy;
      repeat (16) @(posedge I_CLK);
      for (int n = 0; n < 400; n++) begin
         apb(1'b0, st, 32'h0);
         if (q[0] === 1'b1) return;
      end
      n_fail++;
      complete_run();
   endtask : wait_rdy
   // block 7, page pg, then one data byte
   task automatic prog(input logic [5:0] pg, input logic exp);
      apb(1'b1, dt, 32'h80);
      apb(1'b1, dt, 32'h100);
      apb(1'b1, dt, 32'h100);
      apb(1'b1, dt, {22'h0, 4'h7, pg});
      apb(1'b1, dt, 32'h101);
      apb(1'b1, dt, 32'h100);
      apb(1'b1, dt, 32'h2a5);
      check({31'h0, e}, {31'h0, exp}, "program data refusal");
      apb(1'b1, dt, exp ? 32'hff : 32'h10);
      wait_rdy();
   endtask : prog
   initial begin
      {i_psel, i_penable, i_pwrite, fail_pgm} = 4'h0;
      I_SRST = 1'b1;
      i_paddr = 12'h0;
      i_pwdata = 32'h0;
      repeat (10) @(posedge I_CLK);
      I_SRST <= 1'b0;
      @(posedge I_CLK);
      apb(1'b1, dt, 32'h90);
      check({31'h0, e}, 32'h1, "command in power-up");
      apb(1'b1, dt, 32'hff);
      check({31'h0, e}, 32'h0, "reset in power-up");
      $display("power-up test done");
      foreach (rows[k]) begin
         if (rows[k].op == 2'h2) begin
            wait_rdy();
         end else begin
            // a data-port read waits until the strobe sequencer has finished
            if (rows[k].op == 2'h1) apb(1'b0, dt, 32'h0);
            apb(rows[k].op == 2'h0, rows[k].a, rows[k].d);
            check(rows[k].op == 2'h0 ? {31'h0, e} : q, rows[k].e, $sformatf("row %0d", k));
         end
      end
      $display("table test done");
      for (int i = 0; i < 6; i++) begin
         fail_pgm <= (i == 3);
         prog(i < 5 ? 6'h1 : 6'h0, i > 3);
         if (i == 3) begin
            apb(1'b1, dt, 32'h70);
            apb(1'b1, dt, 32'h300);
            apb(1'b0, dt, 32'h0);
            apb(1'b0, ps, 32'h0);
            check(q, 32'he1, "failed program status");
         end
      end
      $display("program order test done");
      I_SRST <= 1'b1;
      repeat (10) @(posedge I_CLK);
      I_SRST <= 1'b0;
      @(posedge I_CLK);
      check({27'h0, o_chip_en_n, o_write_prot_n, o_write_strobe_n, o_read_strobe_n, o_io_oe}, 32'h6,
         "pins after reset");
      $display("reset test done");
      complete_run();
   end
endmodule : flash_status_reset_cmd_rules_bench
